// ==== bench/avalon_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module avalon_host_model
	import status_irq_pkg::*;
(
	input wire logic clock,
	input wire logic waitrequest,
	input wire logic [status_irq_pkg::DATA_W-1:0] readdata,
	output logic [status_irq_pkg::ADDR_W-1:0] address,
	output logic read,
	output logic write,
	output logic [status_irq_pkg::DATA_W-1:0] writedata,
	output logic [status_irq_pkg::BE_W-1:0] byteenable
);
	int hung = 0;
	initial begin
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
		byteenable = '0;
	end
	// ==========================================
	// One transfer, held until the answer edge
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] be, output logic [DATA_W-1:0] q);
		int n;
		@(posedge clock);
		address <= {idx, 2'b00};
		read <= !wr;
		write <= wr;
		writedata <= {24'h00_0000, d};
		byteenable <= be;
		for (n = 0; n < 20; n++) begin
			@(posedge clock);
			if (!waitrequest) break;
		end
		if (waitrequest) hung++;
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		// Stale values would hide a missing qualifier
		address <= ~{idx, 2'b00};
		writedata <= ~{24'h00_0000, d};
	endtask
endmodule
`default_nettype wire

// ==== bench/status_interrupt_mailbox_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module sim_props
	import status_irq_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [status_irq_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [status_irq_pkg::DATA_W-1:0] readdata,
	input wire logic waitrequest,
	input wire logic irq_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire logic req = (read || write) && waitrequest && clk_en;
	wire logic [7:0] idx = address[9:2];
	property p_ack;
		req |=> !waitrequest;
	endproperty
	a_ack: assert property (p_ack) else $error("request not answered next cycle");
	property p_once;
		!waitrequest && clk_en |=> waitrequest;
	endproperty
	a_once: assert property (p_once) else $error("answer longer than one cycle");
	property p_rd_idle;
		!waitrequest && clk_en |=> readdata == 32'h0000_0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
	property p_byte;
		readdata[31:8] == 24'h00_0000;
	endproperty
	a_byte: assert property (p_byte) else $error("upper read data not zero");
	property p_mask2;
		req && read && idx == IDX_SECONDARY_MASK |=> readdata == 32'h0000_0000;
	endproperty
	a_mask2: assert property (p_mask2) else $error("secondary mask readable");
	property p_bit0;
		req && read && idx == IDX_PRIMARY |=> readdata[0] == 1'b0;
	endproperty
	a_bit0: assert property (p_bit0) else $error("reserved status bit set");
	property p_done;
		req && read && idx == IDX_SUBCODE_READ_DONE |=> readdata == 32'h0000_0000;
	endproperty
	a_done: assert property (p_done) else $error("read done register not zero");
	property p_wr;
		req && write |=> readdata == 32'h0000_0000;
	endproperty
	a_wr: assert property (p_wr) else $error("write answered with data");
	c_irq: cover property ($fell(irq_n));
	c_rd: cover property (read && !waitrequest);
	c_wr: cover property (write && !waitrequest);
endmodule
`default_nettype wire

// ==== bench/status_interrupt_mailbox_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module status_interrupt_mailbox_tb_top;
	import status_irq_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] address;
	logic read, write, waitrequest, irq_n;
	logic [DATA_W-1:0] writedata, readdata;
	logic [BE_W-1:0] byteenable;
	unit_events_s unit_events = '0;
	logic laser_on_level = 1'b0;
	logic pll_locked_pin = 1'b0;
	logic spindle_over_range_pin = 1'b0;
	logic clk_en = 1'b1;
	logic [DATA_W-1:0] rev_readdata;
	int num_errors = 0;
	int checks = 0;
	logic [31:0] seed = 32'h2ef6;
	status_interrupt_mailbox DUT (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.unit_events(unit_events), .laser_on_level(laser_on_level),
		.pll_locked_pin(pll_locked_pin), .spindle_over_range_pin(spindle_over_range_pin),
		.irq_n(irq_n));
	// Second revision strap, shares every input with the main instance
	status_interrupt_mailbox #(.MB3_BIT1_READS_ZERO(1'b1)) dut_rev (.clock(clock),
		.sys_rst(sys_rst), .clk_en(clk_en), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(rev_readdata),
		.waitrequest(), .unit_events(unit_events), .laser_on_level(laser_on_level),
		.pll_locked_pin(pll_locked_pin), .spindle_over_range_pin(spindle_over_range_pin),
		.irq_n());
	avalon_host_model host (.clock(clock), .waitrequest(waitrequest), .readdata(readdata),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	function automatic logic [7:0] sec_exp(input logic [7:0] ev, input logic r, input logic f);
		return {ev[7:3], r, f, ev[2]};
	endfunction
	task automatic chk_reg(input logic [31:0] got, input logic [7:0] exp);
		checks++;
		if (got !== {24'h00_0000, exp}) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		num_errors += host.hung;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		forever #2.5 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		report_and_stop();
	end
	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] q;
		logic [7:0] d, acc;
		int i;
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		for (i = 0; i < 3; i++) begin
			seed = xs(seed);
			d = seed[7:0] | 8'h02;
			host.xfer(1, IDX_MAILBOX_ONE + i, d, 4'h1, q);
			host.xfer(0, IDX_PRIMARY, 0, 0, q);
			chk_reg(q, 8'h80 >> i);
			host.xfer(1, IDX_MAILBOX_ONE + i, ~d, 4'h0, q);
			host.xfer(0, IDX_MAILBOX_ONE + i, 0, 0, q);
			chk_reg(q, d);
			if (i == 2) chk_reg(rev_readdata, d & 8'hfd);
			host.xfer(0, IDX_PRIMARY, 0, 0, q);
			chk_reg(q, 8'h00);
		end
		pll_locked_pin <= 1'b1;
		spindle_over_range_pin <= 1'b1;
		unit_events <= 8'h03;
		@(posedge clock);
		unit_events <= '0;
		repeat (4) @(posedge clock);
		host.xfer(0, IDX_PRIMARY, 0, 0, q);
		chk_reg(q, 8'h1e);
		host.xfer(0, IDX_SUBCODE_READ_DONE, 0, 0, q);
		chk_reg(q, 8'h00);
		host.xfer(0, IDX_PRIMARY, 0, 0, q);
		chk_reg(q, 8'h14);
		host.xfer(1, IDX_PRIMARY, 8'h10, 4'h1, q);
		repeat (3) @(posedge clock);
		chk_pin(irq_n, 1'b0);
		pll_locked_pin <= 1'b0;
		spindle_over_range_pin <= 1'b0;
		repeat (5) @(posedge clock);
		chk_pin(irq_n, 1'b1);
		host.xfer(0, IDX_PRIMARY, 0, 0, q);
		chk_reg(q, 8'h00);
		host.xfer(1, IDX_PRIMARY, 8'h00, 4'h1, q);
		acc = 8'h00;
		for (i = 0; i < 6; i++) begin
			seed = xs(seed);
			d = (i == 0) ? 8'hff : seed[7:0];
			unit_events <= d;
			laser_on_level <= ~laser_on_level;
			acc |= sec_exp(d, ~laser_on_level, laser_on_level);
			@(posedge clock);
			unit_events <= '0;
			repeat (3) @(posedge clock);
			host.xfer(0, IDX_SECONDARY_FLAGS, 0, 0, q);
			chk_reg(q, acc);
			// Software clears a subset by writing ones
			host.xfer(1, IDX_SECONDARY_FLAGS, seed[15:8], 4'h1, q);
			acc &= ~seed[15:8];
			host.xfer(0, IDX_SECONDARY_FLAGS, 0, 0, q);
			chk_reg(q, acc);
		end
		// Event pulse on the very edge the write-one clear lands
		fork
			host.xfer(1, IDX_SECONDARY_FLAGS, 8'h80, 4'h1, q);
			begin
				@(posedge clock);
				unit_events <= 8'h80;
				@(posedge clock);
				unit_events <= '0;
			end
		join
		acc |= 8'h80;
		host.xfer(0, IDX_SECONDARY_FLAGS, 0, 0, q);
		chk_reg(q, acc);
		host.xfer(1, IDX_SECONDARY_MASK, 8'hff, 4'h1, q);
		repeat (3) @(posedge clock);
		chk_pin(irq_n, acc == 8'h00);
		host.xfer(1, IDX_SECONDARY_FLAGS, 8'hff, 4'h1, q);
		repeat (3) @(posedge clock);
		chk_pin(irq_n, 1'b1);
		// Frozen clock enable: a pulse must not land
		clk_en <= 1'b0;
		unit_events <= 8'h80;
		@(posedge clock);
		unit_events <= '0;
		clk_en <= 1'b1;
		repeat (3) @(posedge clock);
		chk_pin(irq_n, 1'b1);
		unit_events <= 8'h80;
		@(posedge clock);
		unit_events <= '0;
		repeat (3) @(posedge clock);
		chk_pin(irq_n, 1'b0);
		// Mid-run reset drops flags and masks
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		chk_pin(irq_n, 1'b1);
		host.xfer(0, IDX_SECONDARY_FLAGS, 0, 0, q);
		chk_reg(q, 8'h00);
		host.xfer(0, IDX_SECONDARY_MASK, 0, 0, q);
		chk_reg(q, 8'h00);
		host.xfer(1, 8'h3f, 8'h5a, 4'h1, q);
		host.xfer(0, 8'h3f, 0, 0, q);
		chk_reg(q, 8'h00);
		report_and_stop();
	end
endmodule
bind status_interrupt_mailbox sim_props u_props (.clock(clock), .sys_rst(sys_rst),
	.clk_en(clk_en), .address(address), .read(read), .write(write), .readdata(readdata),
	.waitrequest(waitrequest), .irq_n(irq_n));
`default_nettype wire

// ==== logic/status_interrupt_mailbox.sv ====
// Contract
// - Interrupt pin active low when any status bit and its enable are set.
// - Three byte-wide read/write mailboxes at indices 08, 09, 0A.
// - Primary status 7,6,5 set on mailbox change, cleared on reading that mailbox.
// - Optional revision forces mailbox three bit 1 to read zero.
// - Primary status bit 4 shows PLL lock live, unlatched.
// - Primary bit 3 set on new header, cleared reading subcode-read-done.
// - Primary status bit 2 shows spindle over-range live, unlatched.
// - Primary bit 1 latches buffer overrun; bit 0 reserved.
// - Index 0B reads primary status and writes primary interrupt mask.
// - Primary mask bits 7..1 gate matching status bits; bit 0 reserved.
// - Secondary flags at 20 are sticky, cleared by writing one.
// - Secondary bit 7 set on subcode bank flip.
// - Secondary bit 6 on handshake failure, bit 5 on subcode underrun.
// - Secondary bit 4 set when Q subcode sync written.
// - Secondary bit 3 set when pre-groove sync found.
// - Secondary bits 2 and 1 set on laser-on rise and fall.
// - Secondary bit 0 set when sync offset error exceeds two frames.
// - Write-only secondary mask at 21 gates matching secondary bits.
`timescale 1ns/10ps
`default_nettype none

module status_interrupt_mailbox #(
	parameter bit MB3_BIT1_READS_ZERO = 1'b0
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [status_irq_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [status_irq_pkg::DATA_W-1:0] writedata,
	input wire logic [status_irq_pkg::BE_W-1:0] byteenable,
	output logic [status_irq_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	input wire status_irq_pkg::unit_events_s unit_events,
	input wire logic laser_on_level,
	input wire logic pll_locked_pin,
	input wire logic spindle_over_range_pin,
	output logic irq_n
);
	import status_irq_pkg::*;

	// ==========================================
	// Decoding helper
	function automatic logic hit(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0] idx
	);
		hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
	endfunction

	localparam logic [MAILBOXES-1:0][7:0] MAILBOX_IDX = {
		IDX_MAILBOX_THREE,
		IDX_MAILBOX_TWO,
		IDX_MAILBOX_ONE
	};

	// ==========================================
	// Level synchronisers
	logic [LEVEL_SYNCS-1:0] level_pins;
	logic [LEVEL_SYNCS-1:0] level_sync;

	assign level_pins[SYNC_PLL] = pll_locked_pin;
	assign level_pins[SYNC_SPINDLE] = spindle_over_range_pin;

	// Both sources sit in analog or motor domains
	// Only the second stage feeds logic; the first may be metastable
	genvar g;
	generate
		for (g = 0; g < LEVEL_SYNCS; g++) begin : g_sync
			logic meta_reg;
			logic stable_reg;

			always_ff @(posedge clock) begin
				if (sys_rst) begin
					meta_reg <= 1'b0;
					stable_reg <= 1'b0;
				end else if (clk_en) begin
					meta_reg <= level_pins[g];
					stable_reg <= meta_reg;
				end
			end

			assign level_sync[g] = stable_reg;
		end
	endgenerate

	// ==========================================
	// Bus slave: one wait state, then answer
	logic wait_reg;
	logic wait_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic act;
	logic wr;
	logic rd;

	// Effects fire on the request edge only; the answer cycle cannot repeat them
	always_comb begin
		act = (read || write) && wait_reg;
		wr = act && write && byteenable[0];
		rd = act && read;

		if (act) begin
			wait_next = 1'b0;
		end else begin
			wait_next = 1'b1;
		end
	end

	// ==========================================
	// Mailboxes and primary flags
	logic [MAILBOXES-1:0][REG_W-1:0] mb_reg;
	logic [MAILBOXES-1:0][REG_W-1:0] mb_next;
	logic [MAILBOXES-1:0] mb_chg_reg;
	logic [MAILBOXES-1:0] mb_chg_next;
	logic header_reg;
	logic header_next;
	logic overrun_reg;
	logic overrun_next;
	logic [REG_W-1:0] pmask_reg;
	logic [REG_W-1:0] pmask_next;

	logic [REG_W-1:0] primary_status;
	logic [REG_W-1:0] mb3_view;

	always_comb begin
		for (int i = 0; i < MAILBOXES; i++) begin
			if (wr && hit(address, MAILBOX_IDX[i])) begin
				mb_next[i] = writedata[REG_W-1:0];
			end else begin
				mb_next[i] = mb_reg[i];
			end
			// Rewriting the stored value raises no change flag
			// change flag, set beats read clear
			if (wr && hit(address, MAILBOX_IDX[i])
					&& (writedata[REG_W-1:0] != mb_reg[i])) begin
				mb_chg_next[i] = 1'b1;
			end else if (rd && hit(address, MAILBOX_IDX[i])) begin
				mb_chg_next[i] = 1'b0;
			end else begin
				mb_chg_next[i] = mb_chg_reg[i];
			end
		end

		// header flag, cleared by subcode-read-done read
		// Set wins, so a header landing on the clearing read survives
		if (unit_events.new_header) begin
			header_next = 1'b1;
		end else if (rd && hit(address, IDX_SUBCODE_READ_DONE)) begin
			header_next = 1'b0;
		end else begin
			header_next = header_reg;
		end

		// overrun latch, cleared when primary status is read
		// Only a status read or sys_rst can free this latch
		if (unit_events.buffer_overrun) begin
			overrun_next = 1'b1;
		end else if (rd && hit(address, IDX_PRIMARY)) begin
			overrun_next = 1'b0;
		end else begin
			overrun_next = overrun_reg;
		end

		// writes to 0B land in the mask
		// reserved enable bit kept at zero
		if (wr && hit(address, IDX_PRIMARY)) begin
			pmask_next = writedata[REG_W-1:0] & PRIMARY_MASK_VALID;
		end else begin
			pmask_next = pmask_reg;
		end
	end

	always_comb begin
		primary_status = RESET_BYTE;
		primary_status[BIT_MB_ONE] = mb_chg_reg[0];
		primary_status[BIT_MB_TWO] = mb_chg_reg[1];
		primary_status[BIT_MB_THREE] = mb_chg_reg[2];
		primary_status[BIT_PLL_LOCKED] = level_sync[SYNC_PLL];
		primary_status[BIT_NEW_HEADER] = header_reg;
		primary_status[BIT_SPINDLE] = level_sync[SYNC_SPINDLE];
		primary_status[BIT_OVERRUN] = overrun_reg;
		// Reserved bit 0 keeps the zero default

		// revision strap on mailbox three readback
		mb3_view = mb_reg[2];
		if (MB3_BIT1_READS_ZERO) begin
			mb3_view[BIT_MB3_REVISION] = 1'b0;
		end
	end

	// ==========================================
	// Secondary event flags
	logic laser_prev_reg;
	logic laser_prev_next;
	logic [REG_W-1:0] sflags_reg;
	logic [REG_W-1:0] sflags_next;
	logic [REG_W-1:0] smask_reg;
	logic [REG_W-1:0] smask_next;

	logic [REG_W-1:0] sset;
	logic [REG_W-1:0] sclr;

	always_comb begin
		// Same-clock level, so no synchroniser; reset matches its idle low
		laser_prev_next = laser_on_level;

		sset[7] = unit_events.subcode_bank_flip;
		sset[6] = unit_events.subcode_handshake_fail;
		sset[5] = unit_events.subcode_underrun;
		sset[4] = unit_events.q_subcode_written;
		sset[3] = unit_events.pregroove_sync_found;
		sset[2] = laser_on_level && !laser_prev_reg;
		sset[1] = !laser_on_level && laser_prev_reg;
		sset[0] = unit_events.sync_offset_too_big;

		if (wr && hit(address, IDX_SECONDARY_FLAGS)) begin
			sclr = writedata[REG_W-1:0];
		end else begin
			sclr = RESET_BYTE;
		end

		sflags_next = sset | (sflags_reg & ~sclr);

		// write-only secondary mask
		// Never read back; the read mux returns zero for it
		if (wr && hit(address, IDX_SECONDARY_MASK)) begin
			smask_next = writedata[REG_W-1:0];
		end else begin
			smask_next = smask_reg;
		end
	end

	// ==========================================
	// Interrupt pin
	logic irq_n_reg;
	logic irq_n_next;
	logic primary_hit;
	logic secondary_hit;

	// Registered so decode hazards never glitch the pin
	always_comb begin
		// inverted OR of status AND enable
		primary_hit = |(primary_status & pmask_reg);
		secondary_hit = |(sflags_reg & smask_reg);
		irq_n_next = !(primary_hit || secondary_hit);
	end

	// ==========================================
	// Read mux
	// Registered, so data stand exactly in the answer cycle
	always_comb begin
		rdata_next = READ_ZERO;
		if (rd) begin
			if (hit(address, IDX_MAILBOX_ONE)) begin
				rdata_next[REG_W-1:0] = mb_reg[0];
			end else if (hit(address, IDX_MAILBOX_TWO)) begin
				rdata_next[REG_W-1:0] = mb_reg[1];
			end else if (hit(address, IDX_MAILBOX_THREE)) begin
				rdata_next[REG_W-1:0] = mb3_view;
			end else if (hit(address, IDX_PRIMARY)) begin
				rdata_next[REG_W-1:0] = primary_status;
			end else if (hit(address, IDX_SECONDARY_FLAGS)) begin
				rdata_next[REG_W-1:0] = sflags_reg;
			end else if (hit(address, IDX_SUBCODE_READ_DONE)) begin
				// Only its side effect on primary bit 3 matters
				rdata_next = READ_ZERO;
			end else begin
				// The secondary mask and unmapped indices read as zero
				rdata_next = READ_ZERO;
			end
		end
	end

	// ==========================================
	// State registers
	// Clock enable low holds everything, bus answer included
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wait_reg <= 1'b1;
			rdata_reg <= READ_ZERO;
		end else if (clk_en) begin
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mb_reg <= '0;
			mb_chg_reg <= '0;
			header_reg <= 1'b0;
			overrun_reg <= 1'b0;
			pmask_reg <= RESET_BYTE;
		end else if (clk_en) begin
			mb_reg <= mb_next;
			mb_chg_reg <= mb_chg_next;
			header_reg <= header_next;
			overrun_reg <= overrun_next;
			pmask_reg <= pmask_next;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			laser_prev_reg <= 1'b0;
			sflags_reg <= RESET_BYTE;
			smask_reg <= RESET_BYTE;
		end else if (clk_en) begin
			laser_prev_reg <= laser_prev_next;
			sflags_reg <= sflags_next;
			smask_reg <= smask_next;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_n_reg <= 1'b1;
		end else if (clk_en) begin
			irq_n_reg <= irq_n_next;
		end
	end

	assign readdata = rdata_reg;
	assign waitrequest = wait_reg;
	assign irq_n = irq_n_reg;

endmodule

`default_nettype wire

// ==== shared/status_irq_pkg.sv ====
`default_nettype none
package status_irq_pkg;

	// ==========================================
	// Register indices (byte address = 4 x index)
	localparam logic [7:0] IDX_MAILBOX_ONE = 8'h08;
	localparam logic [7:0] IDX_MAILBOX_TWO = 8'h09;
	localparam logic [7:0] IDX_MAILBOX_THREE = 8'h0a;
	localparam logic [7:0] IDX_PRIMARY = 8'h0b;
	localparam logic [7:0] IDX_SUBCODE_READ_DONE = 8'h14;
	localparam logic [7:0] IDX_SECONDARY_FLAGS = 8'h20;
	localparam logic [7:0] IDX_SECONDARY_MASK = 8'h21;

	// ==========================================
	// Bus shape
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int REG_W = 8;
	localparam int MAILBOXES = 3;
	localparam int LEVEL_SYNCS = 2;

	// ==========================================
	// Primary status bit positions, mailbox three revision bit and synchroniser slots
	localparam int BIT_MB_ONE = 7;
	localparam int BIT_MB_TWO = 6;
	localparam int BIT_MB_THREE = 5;
	localparam int BIT_PLL_LOCKED = 4;
	localparam int BIT_NEW_HEADER = 3;
	localparam int BIT_SPINDLE = 2;
	localparam int BIT_OVERRUN = 1;
	localparam int BIT_MB3_REVISION = 1;
	localparam int SYNC_PLL = 0;
	localparam int SYNC_SPINDLE = 1;

	// ==========================================
	// Reset values and fixed masks
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] PRIMARY_MASK_VALID = 8'hfe;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// Hardware events from the encoder/decoder units, one-cycle pulses
	typedef struct packed {
		logic subcode_bank_flip;
		logic subcode_handshake_fail;
		logic subcode_underrun;
		logic q_subcode_written;
		logic pregroove_sync_found;
		logic sync_offset_too_big;
		logic new_header;
		logic buffer_overrun;
	} unit_events_s;

endpackage

`default_nettype wire
